// ---- eeprom_write_cache.sv ----
// Purpose: Write path of a two-wire serial EEPROM with a 64-byte page cache.
// Assumes: SCL clocks the bit capture; the sequencer runs on sys_clk at 40 MHz.
// Notes:   The array itself is outside; bytes leave through a write strobe port.
// Functional notes
// - No acknowledge for control bytes while programming.
// - Stop after write data starts programming.
// - Poll with write control byte; ack once done.
// - Buffer data in 8x8 byte cache first.
// - Keep caching until stop arrives.
// - Each loaded page costs one 5 ms cycle.
// - Beyond 64 bytes pointer wraps to page 0.
// - Ignore all commands during write cycle.
// - Page-aligned start programs consecutively across blocks.
// - Separate programming cycle per transferred cache page.
// - First byte goes to page 0, low-bit offset.
// - Final bytes fill empty leading page 0 slots.
// - Cache page 0 maps to start page, then onward.
// - Program only bytes that received data.
// - Enter standby after stop or error end.
// - Inhibit programming on low supply; monitor off standby.
// - Respond only when chip-select bits match pins.
// - Data changes only while clock low.
// - Drive data line low only, else release.
// - Direction bit: one read, zero write.
`include "eeprom_cache_map.svh"
`timescale 1ns/100ps
`default_nettype none

module eeprom_write_cache #(
  parameter int PROG_CYCLES = `PAGE_PROG_NS / `SYS_CLK_NS
) (
  input  wire logic                    sys_clk,       // Core clock, 40 MHz.
  input  wire logic                    rst_b,         // Asynchronous reset, active low.
  input  wire logic                    scl,           // Serial clock from the master.
  input  wire logic                    sdaIn,         // Level seen on the data line.
  output logic                         sdaOut,        // Value driven onto the data line.
  output logic                         sdaOe_b,       // Data line drive enable, low drives.
  input  wire logic [2:0]              chipSelInputs, // Chip address straps.
  input  wire logic                    supplyLow,     // Supply monitor reports low voltage.
  output logic                         monitorEn,     // Supply monitor enable.
  output logic                         standby,       // Device is in standby.
  output logic                         progBusy,      // Internal write cycle running.
  output logic                         arrayWrEn,     // One-cycle array byte write.
  output logic [`ARRAY_AW-1:0]         arrayWrAddr,   // Array byte address.
  output logic [7:0]                   arrayWrData    // Array byte data.
);

  localparam logic [17:0] PROG_LAST = 18'(PROG_CYCLES - 1);

  eeprom_cache_pkg::state_type stateQ;

  logic [7:0]              linkShiftQ;
  logic [1:0]              sclSyncQ;
  logic [1:0]              sdaSyncQ;
  logic [1:0]              selSyncQ [3];
  logic [1:0]              lowSyncQ;
  logic                    sclPrevQ;
  logic                    sdaPrevQ;
  logic                    sclRise;
  logic                    sclFall;
  logic                    startDet;
  logic                    stopDet;
  logic [3:0]              bitCntQ;
  logic                    byteDone;
  logic [7:0]              rxByte;
  logic                    ackPendQ;
  logic                    driveQ;
  logic [2:0]              chipSel;
  logic                    supplyLowS;
  logic                    ctrlMatch;
  logic [4:0]              addrHiQ;
  logic [`ARRAY_AW-1:0]    startAddrQ;
  logic [7:0]              cacheMem [`CACHE_BYTES];
  logic [`CACHE_BYTES-1:0] cacheValidQ;
  logic [5:0]              wrPtrQ;
  logic                    anyLoaded;
  logic [2:0]              progPageQ;
  logic [17:0]             progTimerQ;
  logic [5:0]              progIdx;
  logic                    pageLoaded;
  logic                    pageDone;
  logic                    lastPageDone;
  logic                    writeAllowed;
  logic [9:0]              arrayPage;

  // Link domain: data bits are captured on the rising edge of the serial clock.
  always_ff @(posedge scl or negedge rst_b) begin
    if (!rst_b) begin
      linkShiftQ <= 8'h00;
    end else begin
      linkShiftQ <= {linkShiftQ[6:0], sdaIn};
    end
  end

  // Two-flop synchronisers for every pin that the core domain reads.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclSyncQ <= 2'h3;
      sdaSyncQ <= 2'h3;
      lowSyncQ <= 2'h0;
      for (int i = 0; i < 3; i++) begin
        selSyncQ[i] <= 2'h0;
      end
    end else begin
      sclSyncQ <= {sclSyncQ[0], scl};
      sdaSyncQ <= {sdaSyncQ[0], sdaIn};
      lowSyncQ <= {lowSyncQ[0], supplyLow};
      for (int i = 0; i < 3; i++) begin
        selSyncQ[i] <= {selSyncQ[i][0], chipSelInputs[i]};
      end
    end
  end

  // Previous synchronised levels for edge and condition detection.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclPrevQ <= 1'h1;
      sdaPrevQ <= 1'h1;
    end else begin
      sclPrevQ <= sclSyncQ[1];
      sdaPrevQ <= sdaSyncQ[1];
    end
  end

  // Data falling while the clock is high is a start; rising is a stop.
  assign sclRise    = sclSyncQ[1] & ~sclPrevQ;
  assign sclFall    = ~sclSyncQ[1] & sclPrevQ;
  assign startDet   = sclSyncQ[1] & sclPrevQ & sdaPrevQ & ~sdaSyncQ[1];
  assign stopDet    = sclSyncQ[1] & sclPrevQ & ~sdaPrevQ & sdaSyncQ[1];
  assign chipSel    = {selSyncQ[2][1], selSyncQ[1][1], selSyncQ[0][1]};
  assign supplyLowS = lowSyncQ[1];

  // The link byte is stable for a whole clock period after its eighth edge,
  // so the core reads it only on the synchronised copy of that edge.
  assign byteDone = sclRise && (bitCntQ == `LAST_BIT_IDX);
  assign rxByte   = linkShiftQ;

  // Bit position inside the current nine-clock frame.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bitCntQ <= 4'h0;
    end else if (startDet || stopDet) begin
      bitCntQ <= 4'h0;
    end else if (sclRise) begin
      bitCntQ <= (bitCntQ == `ACK_BIT_IDX) ? 4'h0 : bitCntQ + 4'h1;
    end
  end

  // Control byte decode: prefix, matching selects and write direction.
  assign ctrlMatch = (rxByte[`CTRL_TYPE_HI:`CTRL_TYPE_LO] == `CTRL_TYPE_PREFIX) &&
                     (rxByte[`CTRL_SEL_HI:`CTRL_SEL_LO] == chipSel) &&
                     (rxByte[`CTRL_DIR_BIT] == `DIR_WRITE);

  // Sequencer: framing, address load, data caching and programming.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stateQ <= eeprom_cache_pkg::ST_STANDBY;
    end else begin
      unique case (stateQ)
        eeprom_cache_pkg::ST_PROGRAM: begin
          if (lastPageDone) begin
            stateQ <= eeprom_cache_pkg::ST_STANDBY;
          end
        end
        eeprom_cache_pkg::ST_STANDBY,
        eeprom_cache_pkg::ST_CONTROL,
        eeprom_cache_pkg::ST_ADDR_HI,
        eeprom_cache_pkg::ST_ADDR_LO,
        eeprom_cache_pkg::ST_DATA,
        eeprom_cache_pkg::ST_SKIP: begin
          if (startDet) begin
            stateQ <= eeprom_cache_pkg::ST_CONTROL;
          end else if (stopDet) begin
            if (stateQ == eeprom_cache_pkg::ST_DATA && anyLoaded) begin
              stateQ <= eeprom_cache_pkg::ST_PROGRAM;
            end else begin
              stateQ <= eeprom_cache_pkg::ST_STANDBY;
            end
          end else if (byteDone) begin
            unique case (stateQ)
              eeprom_cache_pkg::ST_CONTROL: begin
                stateQ <= ctrlMatch ? eeprom_cache_pkg::ST_ADDR_HI
                                    : eeprom_cache_pkg::ST_SKIP;
              end
              eeprom_cache_pkg::ST_ADDR_HI: stateQ <= eeprom_cache_pkg::ST_ADDR_LO;
              eeprom_cache_pkg::ST_ADDR_LO: stateQ <= eeprom_cache_pkg::ST_DATA;
              eeprom_cache_pkg::ST_DATA:    stateQ <= eeprom_cache_pkg::ST_DATA;
              eeprom_cache_pkg::ST_STANDBY,
              eeprom_cache_pkg::ST_SKIP,
              eeprom_cache_pkg::ST_PROGRAM: stateQ <= stateQ;
              default:                      stateQ <= eeprom_cache_pkg::ST_STANDBY;
            endcase
          end
        end
        default: stateQ <= eeprom_cache_pkg::ST_STANDBY;
      endcase
    end
  end

  // Acknowledge decision; nothing is acknowledged while programming.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ackPendQ <= 1'h0;
    end else if (startDet || stopDet || stateQ == eeprom_cache_pkg::ST_PROGRAM) begin
      ackPendQ <= 1'h0;
    end else if (byteDone) begin
      unique case (stateQ)
        eeprom_cache_pkg::ST_CONTROL: ackPendQ <= ctrlMatch;
        eeprom_cache_pkg::ST_ADDR_HI,
        eeprom_cache_pkg::ST_ADDR_LO,
        eeprom_cache_pkg::ST_DATA:    ackPendQ <= 1'h1;
        default:                      ackPendQ <= 1'h0;
      endcase
    end else if (sclRise && bitCntQ == `ACK_BIT_IDX) begin
      ackPendQ <= 1'h0;
    end
  end

  // The line is pulled low only after a clock fall, and released after a clock fall or on a start or stop.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      driveQ <= 1'h0;
    end else if (startDet || stopDet) begin
      driveQ <= 1'h0;
    end else if (sclFall) begin
      driveQ <= ackPendQ && (bitCntQ == `ACK_BIT_IDX);
    end
  end

  assign sdaOut  = 1'h0;
  assign sdaOe_b = ~driveQ;

  // Start address: upper bits from the first address byte, rest from the second.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      addrHiQ    <= 5'h00;
      startAddrQ <= '0;
    end else if (byteDone && stateQ == eeprom_cache_pkg::ST_ADDR_HI) begin
      addrHiQ <= rxByte[`ADDR_HI_BITS];
    end else if (byteDone && stateQ == eeprom_cache_pkg::ST_ADDR_LO) begin
      startAddrQ <= {addrHiQ, rxByte};
    end
  end

  // Cache pointer: starts in page 0 at the low address bits, then wraps freely.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtrQ      <= `PTR_RESET;
      cacheValidQ <= '0;
    end else if (byteDone && stateQ == eeprom_cache_pkg::ST_ADDR_LO) begin
      wrPtrQ      <= {3'h0, rxByte[2:0]};
      cacheValidQ <= '0;
    end else if (byteDone && stateQ == eeprom_cache_pkg::ST_DATA) begin
      wrPtrQ              <= wrPtrQ + 6'h01;
      cacheValidQ[wrPtrQ] <= 1'h1;
    end
  end

  // Cache storage; later bytes simply overwrite older ones at the same slot.
  always_ff @(posedge sys_clk) begin
    if (byteDone && stateQ == eeprom_cache_pkg::ST_DATA) begin
      cacheMem[wrPtrQ] <= rxByte;
    end
  end

  // Programming walk: one timed cycle per loaded page, empty pages skipped.
  assign anyLoaded    = |cacheValidQ;
  assign progIdx      = {progPageQ, progTimerQ[2:0]};
  assign pageLoaded   = |cacheValidQ[{progPageQ, 3'h0} +: 8];
  assign pageDone     = !pageLoaded || (progTimerQ == PROG_LAST);
  assign lastPageDone = (stateQ == eeprom_cache_pkg::ST_PROGRAM) && pageDone &&
                        (progPageQ == 3'(`CACHE_PAGES - 1));
  assign arrayPage    = startAddrQ[`ARRAY_AW-1:3] + {7'h00, progPageQ};
  assign writeAllowed = (stateQ == eeprom_cache_pkg::ST_PROGRAM) && pageLoaded &&
                        (progTimerQ < 18'h8) && cacheValidQ[progIdx] &&
                        monitorEn && !supplyLowS;

  // Page and timer counters of the internal write cycle.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      progPageQ  <= 3'h0;
      progTimerQ <= 18'h0;
    end else if (stateQ != eeprom_cache_pkg::ST_PROGRAM) begin
      progPageQ  <= 3'h0;
      progTimerQ <= 18'h0;
    end else if (pageDone) begin
      progPageQ  <= progPageQ + 3'h1;
      progTimerQ <= 18'h0;
    end else begin
      progTimerQ <= progTimerQ + 18'h1;
    end
  end

  // Byte strobes to the array, one per loaded byte at the head of a page cycle while the supply is not low.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      arrayWrEn   <= 1'h0;
      arrayWrAddr <= '0;
      arrayWrData <= 8'h00;
    end else begin
      arrayWrEn   <= writeAllowed;
      arrayWrAddr <= {arrayPage, progTimerQ[2:0]};
      arrayWrData <= cacheMem[progIdx];
    end
  end

  // Status levels; the supply monitor only runs outside standby.
  assign standby   = (stateQ == eeprom_cache_pkg::ST_STANDBY);
  assign monitorEn = !standby;
  assign progBusy  = (stateQ == eeprom_cache_pkg::ST_PROGRAM);

  // Checks run in the core domain and are idle during reset.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // Cycles spent inside the current loaded page; restarts at every page end.
  logic [17:0] busyCntQ;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busyCntQ <= 18'h0;
    end else begin
      busyCntQ <= (progBusy && pageLoaded && !pageDone) ? busyCntQ + 18'h1 : 18'h0;
    end
  end

  chk_busy_no_ack: assert property (progBusy |-> sdaOe_b)
    else $error("Data line driven during a write cycle.");
  chk_busy_ignore: assert property (progBusy && byteDone |=> !ackPendQ)
    else $error("Byte accepted during a write cycle.");
  chk_stop_prog: assert property
      (stateQ == eeprom_cache_pkg::ST_DATA && stopDet && !startDet && anyLoaded
       |=> progBusy)
    else $error("Stop after data did not start programming.");
  chk_first_slot: assert property
      (stateQ == eeprom_cache_pkg::ST_ADDR_LO && byteDone && !startDet && !stopDet
       |=> wrPtrQ[5:3] == 3'h0 && wrPtrQ[2:0] == $past(rxByte[2:0]))
    else $error("First data slot not in cache page 0.");
  chk_ptr_wrap: assert property
      (stateQ == eeprom_cache_pkg::ST_DATA && byteDone && !startDet && !stopDet
       |=> wrPtrQ == $past(wrPtrQ) + 6'h01)
    else $error("Cache pointer did not advance modulo 64.");
  chk_page_time: assert property (busyCntQ <= PROG_LAST + 18'h1)
    else $error("Page programming cycle overran its limit.");
  chk_write_gate: assert property (arrayWrEn |-> $past(progBusy) && !$past(supplyLowS))
    else $error("Array write outside a write cycle or with low supply.");
  chk_done_standby: assert property (lastPageDone |=> standby)
    else $error("Standby not entered after the last page.");
  chk_drive_edge: assert property ($fell(sdaOe_b) |-> !sclPrevQ)
    else $error("Data line pulled low while the clock was high.");
  chk_ctrl_mismatch: assert property
      (stateQ == eeprom_cache_pkg::ST_CONTROL && byteDone && !startDet && !stopDet &&
       rxByte[`CTRL_SEL_HI:`CTRL_SEL_LO] != chipSel |=> !ackPendQ)
    else $error("Acknowledge pending for a foreign chip select.");

  // Further guards: a quiet array in standby, a released line after stop and in skipped frames.
  chk_idle_quiet: assert property (standby |-> !arrayWrEn)
    else $error("Array write while in standby.");
  chk_stop_release: assert property (stopDet |=> sdaOe_b)
    else $error("Data line still driven after a stop.");
  chk_skip_silent: assert property (stateQ == eeprom_cache_pkg::ST_SKIP |-> sdaOe_b)
    else $error("Data line driven in a frame for another device.");

  // Main scenarios: programming, wrap, acknowledge, low supply and skipped frames.
  cov_program: cover property ($rose(progBusy));
  cov_low_supply: cover property (progBusy && supplyLowS);
  cov_skip: cover property (stateQ == eeprom_cache_pkg::ST_SKIP);
  cov_wrap: cover property (byteDone && stateQ == eeprom_cache_pkg::ST_DATA &&
                            wrPtrQ == 6'h3f);
  cov_ack: cover property ($fell(sdaOe_b));

endmodule

`default_nettype wire

// ---- eeprom_cache_map.svh ----
// Purpose: Constants for the serial EEPROM write cache.
// Assumes: System clock of 40 MHz.
// Notes:   Times are given in their own unit; cycle counts derive from them.
`ifndef EEPROM_CACHE_MAP_SVH
`define EEPROM_CACHE_MAP_SVH

// System clock period in nanoseconds.
`define SYS_CLK_NS        25
// Longest programming time of one cache page in nanoseconds.
`define PAGE_PROG_NS      5000000
// Fixed device-type prefix in the upper nibble of the control byte.
`define CTRL_TYPE_PREFIX  4'ha
// Field positions inside the control byte.
`define CTRL_TYPE_HI      7
`define CTRL_TYPE_LO      4
`define CTRL_SEL_HI       3
`define CTRL_SEL_LO       1
`define CTRL_DIR_BIT      0
// Direction value that requests a write or an address load.
`define DIR_WRITE         1'h0
// Bit index of the ninth (acknowledge) clock inside a byte frame.
`define ACK_BIT_IDX       4'h8
// Bit index of the last data bit inside a byte frame.
`define LAST_BIT_IDX      4'h7
// Cache geometry: pages, total cache bytes and pointer reset value.
`define CACHE_PAGES       8
`define CACHE_BYTES       64
`define PTR_RESET         6'h00
// Width of the array byte address.
`define ARRAY_AW          13
// Position of the upper address bits held in the first address byte.
`define ADDR_HI_BITS      4:0

`endif

// ---- eeprom_cache_pkg.sv ----
// Purpose: Types shared by the serial EEPROM write cache.
// Assumes: Constants live in eeprom_cache_map.svh.
// Notes:   One illegal state code exists and is caught by a default arm.
package eeprom_cache_pkg;

  // Bus-facing sequencer states.
  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000,
    ST_CONTROL = 3'b001,
    ST_ADDR_HI = 3'b010,
    ST_ADDR_LO = 3'b011,
    ST_DATA    = 3'b100,
    ST_SKIP    = 3'b101,
    ST_PROGRAM = 3'b110
  } state_type;

endpackage

// ---- i2c_master_model.sv ----
// Purpose: Behavioural two-wire bus master that drives the serial clock and data.
// Assumes: Link base clock of 15 ns; a half bit time of HALF link clocks (>= 600 ns).
// Notes:   The serial clock stands low between frames and high only after a stop; released data floats to the pull-up.
`timescale 1ns/100ps
`default_nettype none

module i2c_master_model #(
  parameter int HALF = 41
) (
  input  wire logic linkClk, // Link base clock.
  input  wire logic sdaWire, // Resolved level of the data line.
  output var  logic scl,     // Serial clock to the device.
  output var  logic mstOe_b  // Low pulls the data line low.
);
  // Idle bus with both lines released.
  initial begin
    scl = 1'h1;
    mstOe_b = 1'h1;
  end

  // Waits one half bit time on the link clock.
  task automatic wait_half();
    repeat (HALF) @(posedge linkClk);
  endtask

  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    mstOe_b = 1'h1;
    wait_half();
    scl = 1'h1;
    wait_half();
    mstOe_b = 1'h0;
    wait_half();
    scl = 1'h0;
  endtask

  // Stop: data rises while the clock is high, then the bus rests.
  task automatic stop();
    mstOe_b = 1'h0;
    wait_half();
    scl = 1'h1;
    wait_half();
    mstOe_b = 1'h1;
    wait_half();
  endtask

  // Sends the top n bits MSB first; a whole byte also clocks the acknowledge slot.
  task automatic send_byte(input logic [7:0] b, input int n, output logic ack);
    ack = 1'h0;
    for (int i = 7; i > 7 - n; i--) begin
      mstOe_b = b[i];
      wait_half();
      scl = 1'h1;
      wait_half();
      scl = 1'h0;
    end
    if (n == 8) begin
      mstOe_b = 1'h1;
      wait_half();
      scl = 1'h1;
      wait_half();
      ack = ~sdaWire;
      scl = 1'h0;
    end
  endtask
endmodule
`default_nettype wire

// ---- serial_eeprom_write_cache_tb_top.sv ----
// Purpose: Self-checking bench for the serial EEPROM write cache.
// Assumes: Programming time shortened to PROG cycles; seed fixed at 78.
// Notes:   Array strobes are collected and compared against a cache model.
`include "eeprom_cache_map.svh"
`timescale 1ns/100ps
`default_nettype none

module serial_eeprom_write_cache_tb_top;
  localparam int PROG = 1200;
  logic sys_clk = 1'h0, linkClk = 1'h0, rst_b = 1'h0, supplyLow = 1'h0;
  logic [2:0] chipSelInputs = 3'h0;
  logic scl, mstOe_b, sdaOut, sdaOe_b, monitorEn, standby, progBusy, arrayWrEn;
  logic [12:0] arrayWrAddr;
  logic [7:0] arrayWrData;
  logic [7:0] dQ[$];
  logic [20:0] eQ[$];
  logic [20:0] gotQ[$];
  int miscompares = 0, n_checks = 0, cyc = 0, busyCyc = 0;
  wire logic sdaIn = sdaOe_b & mstOe_b; // Open drain with pull-up.

  always #12.5 sys_clk = ~sys_clk;
  always #7.5 linkClk = ~linkClk;

  eeprom_write_cache #(.PROG_CYCLES(PROG)) eeprom_write_cache_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe_b(sdaOe_b), .chipSelInputs(chipSelInputs), .supplyLow(supplyLow),
    .monitorEn(monitorEn), .standby(standby), .progBusy(progBusy),
    .arrayWrEn(arrayWrEn), .arrayWrAddr(arrayWrAddr), .arrayWrData(arrayWrData));

  i2c_master_model i2c_master_model_i (
    .linkClk(linkClk), .sdaWire(sdaIn), .scl(scl), .mstOe_b(mstOe_b));

  // Collects every array byte strobe and cuts a hung run short.
  always @(posedge sys_clk) begin
    if (arrayWrEn === 1'h1) gotQ.push_back({arrayWrAddr, arrayWrData});
    if (progBusy === 1'h1) busyCyc++;
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [7:0] ctrl(input logic [2:0] s, input logic dir);
    return {`CTRL_TYPE_PREFIX, s, dir};
  endfunction

  // Builds the expected strobe list from dQ; returns the number of loaded pages.
  function automatic int expect_list(input logic [12:0] a);
    logic [7:0] cv [64];
    bit us [64];
    int pages, lp;
    pages = 0;
    lp = -1;
    eQ.delete();
    foreach (us[i]) us[i] = 1'b0;
    foreach (dQ[k]) begin
      cv[(a[2:0] + k) % 64] = dQ[k];
      us[(a[2:0] + k) % 64] = 1'b1;
    end
    for (int s = 0; s < 64; s++) begin
      if (us[s]) begin
        eQ.push_back({a[12:3] + 10'(s / 8), 3'(s % 8), cv[s]});
        if (s / 8 != lp) pages++;
        lp = s / 8;
      end
    end
    return pages;
  endfunction

  task automatic cycles(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Sends one control byte after a start and compares its acknowledge.
  task automatic probe(input logic [7:0] c, input logic expAck);
    logic ack;
    i2c_master_model_i.start();
    i2c_master_model_i.send_byte(c, 8, ack);
    check(ack, expAck);
  endtask

  // Full cache write with busy polling, completion and strobe comparison.
  task automatic do_write(input logic [12:0] a, input int n, input logic low, input string nm);
    logic ack;
    int pages, w;
    dQ.delete();
    for (int k = 0; k < n; k++) dQ.push_back(8'($urandom));
    pages = expect_list(a);
    gotQ.delete();
    probe(ctrl(chipSelInputs, 1'h0), 1'h1);
    i2c_master_model_i.send_byte({3'h0, a[12:8]}, 8, ack);
    check(ack, 1'h1);
    i2c_master_model_i.send_byte(a[7:0], 8, ack);
    check(ack, 1'h1);
    foreach (dQ[k]) begin
      i2c_master_model_i.send_byte(dQ[k], 8, ack);
      check(ack, 1'h1);
    end
    check(gotQ.size(), 0);
    @(negedge sys_clk);
    supplyLow = low;
    busyCyc = 0;
    i2c_master_model_i.stop();
    cycles(8);
    check(progBusy, 1'h1);
    check(monitorEn, 1'h1);
    probe(ctrl(chipSelInputs, 1'h0), 1'h0);
    i2c_master_model_i.send_byte(a[7:0], 8, ack);
    check(ack, 1'h0);
    i2c_master_model_i.stop();
    w = 0;
    while (progBusy === 1'h1 && w < 20000) begin
      @(negedge sys_clk);
      w++;
    end
    check(busyCyc >= pages * PROG && busyCyc <= pages * PROG + 8, 1'h1);
    check(standby, 1'h1);
    check(monitorEn, 1'h0);
    if (low) check(gotQ.size(), 0);
    else begin
      check(gotQ.size(), eQ.size());
      foreach (eQ[i]) if (i < gotQ.size()) check(gotQ[i], eQ[i]);
    end
    supplyLow = 1'h0;
    probe(ctrl(chipSelInputs, 1'h0), 1'h1);
    i2c_master_model_i.stop();
    cycles(10);
    check(progBusy, 1'h0);
    $display("test done: %s", nm);
  endtask

  // Main sequence.
  initial begin
    logic ack;
    void'($urandom(78));
    cycles(10);
    rst_b = 1'h1;
    chipSelInputs = 3'($urandom);
    cycles(6);
    check(standby, 1'h1);
    check(sdaOe_b, 1'h1);
    check(sdaOut, 1'h0);
    do_write(13'h0005, 2, 1'h0, "short");
    do_write({8'($urandom), 5'h02}, 66, 1'h0, "wrap");
    do_write(13'h01f8, 16, 1'h0, "aligned");
    do_write(13'($urandom), 3, 1'h1, "lowsupply");
    for (int s = 0; s < 8; s++) begin
      probe(ctrl(3'(s), 1'h0), 3'(s) == chipSelInputs);
      i2c_master_model_i.stop();
    end
    probe(ctrl(chipSelInputs, 1'h1), 1'h0);
    probe({4'h5, chipSelInputs, 1'h0}, 1'h0);
    i2c_master_model_i.stop();
    $display("test done: select");
    probe(ctrl(chipSelInputs, 1'h0), 1'h1);
    i2c_master_model_i.send_byte(8'h00, 8, ack);
    check(ack, 1'h1);
    i2c_master_model_i.send_byte(8'h10, 8, ack);
    check(ack, 1'h1);
    i2c_master_model_i.send_byte(8'($urandom), 3, ack);
    i2c_master_model_i.stop();
    cycles(10);
    check(progBusy, 1'h0);
    check(standby, 1'h1);
    $display("test done: abort");
    final_report();
  end
endmodule
`default_nettype wire
